// ---- rtl/rtcam_regs.svh ----
/*
 * register offsets, field positions, reset values and divider taps
 * of the alarm compare and multifunction pin block.
 * assumes byte-wide registers reached by an 8-bit register address.
 */
`ifndef RTCAM_REGS_SVH
`define RTCAM_REGS_SVH

`define RTCAM_OFF_CONTROL    8'h07
`define RTCAM_OFF_A0_SEC     8'h0A
`define RTCAM_OFF_A0_MIN     8'h0B
`define RTCAM_OFF_A0_HOUR    8'h0C
`define RTCAM_OFF_A0_WEEKDAY 8'h0D
`define RTCAM_OFF_A0_DATE    8'h0E
`define RTCAM_OFF_A0_MONTH   8'h0F
`define RTCAM_OFF_A1_SEC     8'h11
`define RTCAM_OFF_A1_MIN     8'h12
`define RTCAM_OFF_A1_HOUR    8'h13
`define RTCAM_OFF_A1_WEEKDAY 8'h14
`define RTCAM_OFF_A1_DATE    8'h15
`define RTCAM_OFF_A1_MONTH   8'h16

`define RTCAM_RST_CONTROL    8'h80
`define RTCAM_RST_WEEKDAY    8'h01
`define RTCAM_RST_DATE       8'h01
`define RTCAM_RST_MONTH      8'h01
`define RTCAM_RST_ZERO       8'h00

`define RTCAM_CTL_LEVEL      7
`define RTCAM_CTL_SQW_EN     6
`define RTCAM_CTL_A1_EN      5
`define RTCAM_CTL_A0_EN      4
`define RTCAM_CTL_EXT_CLK    3
`define RTCAM_CTL_TRIM       2

`define RTCAM_WK_POL         7
`define RTCAM_WK_FLAG        3

`define RTCAM_HOUR_FMT       6
`define RTCAM_SEC_MASK       8'h7F
`define RTCAM_HOUR_MASK      8'h3F
`define RTCAM_DATE_MASK      8'h3F
`define RTCAM_MONTH_MASK     8'h1F
`define RTCAM_WEEKDAY_MASK   8'h07

`define RTCAM_SEL_SEC        3'h0
`define RTCAM_SEL_MIN        3'h1
`define RTCAM_SEL_HOUR       3'h2
`define RTCAM_SEL_WEEKDAY    3'h3
`define RTCAM_SEL_DATE       3'h4
`define RTCAM_SEL_ALL        3'h7

`define RTCAM_RATE_1HZ       2'h0
`define RTCAM_RATE_4K        2'h1
`define RTCAM_RATE_8K        2'h2
`define RTCAM_RATE_FULL      2'h3

`define RTCAM_TAP_DIV4       1
`define RTCAM_TAP_DIV8       2
`define RTCAM_TAP_64HZ       8
`define RTCAM_TAP_1HZ        14

`endif

// ---- rtl/rtcam_pkg.sv ----
/*
 * types of the alarm compare and multifunction pin block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package rtcam_pkg;

    typedef enum logic [2:0] {
        RTCAM_MODE_GPIO  = 3'b001,
        RTCAM_MODE_ALARM = 3'b010,
        RTCAM_MODE_SQW   = 3'b100
    } rtcam_mode_type;

endpackage : rtcam_pkg

// ---- rtl/rtcam_alarm_output.sv ----
/*
 * alarm compare registers, sticky match flags and the open-drain
 * multifunction pin multiplexer of a real-time clock.
 * assumes the serial front end gives one-cycle register strobes, the
 * timekeeping counters give a one-cycle update pulse with BCD values,
 * and the oscillator level and trim strobes are synchronous to clock.
 */
// Operation
// - polarity bit 1 makes asserted pin high, 0 makes it low
// - match select picks seconds, minutes, hours, weekday, date or all
// - hours compare honours 12-hour or 24-hour format
// - flag sets on match and stays until host clears it
// - flag cleared during a lasting match sets again
// - writes never set flag; a write to that alarm's own weekday register clears it
// - weekday field is bits 2-0, values 1 to 7, meaning host-defined
// - date register holds tens 0-3 and ones; bits 7-6 read zero
// - month register holds tens bit and ones; bits 7-5 read zero
// - square wave enable wins, then alarm enables, else general output
// - pin is open drain: pulls low or releases only
// - general output mode pin follows level bit; ignored elsewhere
// - each alarm has its own enable bit
// - external clock select bit opens the crystal input clock path
// - coarse trim with square wave outputs trimmed 64 Hz, ignores rate
// - rate select 00=1 Hz, 01=4.096k, 10=8.192k, 11=32.768 kHz
// - square wave divides oscillator by 1, 4, 8 or 32768
// - trimming affects divided outputs; full-rate output passes untrimmed
// - single alarm: pin is flag, or inverse when polarity is 0
// - dual alarm: OR of flags, or inverted AND when polarity is 0
`include "rtcam_regs.svh"

module rtcam_alarm_output
    import rtcam_pkg::*;
#(
    parameter int DIV_WIDTH = 15
) (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       time_update,
    input  wire logic [7:0] time_seconds,
    input  wire logic [7:0] time_minutes,
    input  wire logic [7:0] time_hours,
    input  wire logic [7:0] time_weekday,
    input  wire logic [7:0] time_date,
    input  wire logic [7:0] time_month,
    input  wire logic       osc_level,
    input  wire logic       trim_add,
    input  wire logic       trim_drop,
    output logic            multifunction_output_pin_out,
    output logic            multifunction_output_pin_oe,
    output logic            external_clock_input_select,
    output logic            first_alarm_flag,
    output logic            second_alarm_flag
);

    logic           reset_meta_n;
    logic           rst_n;
    logic [7:0]     rtc_control;
    logic           alarm_output_polarity;
    logic [2:0]     alarm_match_select [2];
    logic [2:0]     weekday_value      [2];
    logic [7:0]     alarm_seconds      [2];
    logic [7:0]     alarm_minutes      [2];
    logic [7:0]     alarm_hours        [2];
    logic [7:0]     alarm_date         [2];
    logic [7:0]     alarm_month        [2];
    logic [1:0]     alarm_match_flag;
    logic [1:0]     match_now;
    logic [1:0]     weekday_write;
    logic           hour_format;
    logic           osc_prev;
    logic           osc_rise;
    logic [DIV_WIDTH-1:0] div_count;
    logic           sqw_level;
    logic           alarm_level;
    logic           next_pin_level;
    logic [7:0]     next_rdata;
    rtcam_mode_type mode;

    // async assert, release through two flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reset_meta_n <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            reset_meta_n <= 1'b1;
            rst_n        <= reset_meta_n;
        end
    end

    assign hour_format = time_hours[`RTCAM_HOUR_FMT];
    assign weekday_write[0] = reg_write && reg_addr == `RTCAM_OFF_A0_WEEKDAY;
    assign weekday_write[1] = reg_write && reg_addr == `RTCAM_OFF_A1_WEEKDAY;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rtc_control <= `RTCAM_RST_CONTROL;
        end else if (reg_write && reg_addr == `RTCAM_OFF_CONTROL) begin
            rtc_control <= reg_wdata;
        end
    end

    // either weekday register writes the same polarity bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            alarm_output_polarity <= 1'b0;
        end else if (|weekday_write) begin
            alarm_output_polarity <= reg_wdata[`RTCAM_WK_POL];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_alarm
            logic [7:0] off_sec;
            logic [7:0] off_min;
            logic [7:0] off_hour;
            logic [7:0] off_date;
            logic [7:0] off_month;
            logic       sec_eq;
            logic       min_eq;
            logic       hour_eq;
            logic       wk_eq;
            logic       date_eq;
            logic       month_eq;
            logic       enabled;

            assign off_sec   = g ? `RTCAM_OFF_A1_SEC   : `RTCAM_OFF_A0_SEC;
            assign off_min   = g ? `RTCAM_OFF_A1_MIN   : `RTCAM_OFF_A0_MIN;
            assign off_hour  = g ? `RTCAM_OFF_A1_HOUR  : `RTCAM_OFF_A0_HOUR;
            assign off_date  = g ? `RTCAM_OFF_A1_DATE  : `RTCAM_OFF_A0_DATE;
            assign off_month = g ? `RTCAM_OFF_A1_MONTH : `RTCAM_OFF_A0_MONTH;
            assign enabled   = g ? rtc_control[`RTCAM_CTL_A1_EN]
                                 : rtc_control[`RTCAM_CTL_A0_EN];

            // unused bits are dropped on write so they read zero
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    alarm_seconds[g]      <= `RTCAM_RST_ZERO;
                    alarm_minutes[g]      <= `RTCAM_RST_ZERO;
                    alarm_hours[g]        <= `RTCAM_RST_ZERO;
                    alarm_date[g]         <= `RTCAM_RST_DATE;
                    alarm_month[g]        <= `RTCAM_RST_MONTH;
                    alarm_match_select[g] <= 3'h0;
                    weekday_value[g]      <= 3'h1;
                end else if (reg_write) begin
                    if (reg_addr == off_sec) begin
                        alarm_seconds[g] <= reg_wdata & `RTCAM_SEC_MASK;
                    end else if (reg_addr == off_min) begin
                        alarm_minutes[g] <= reg_wdata & `RTCAM_SEC_MASK;
                    end else if (reg_addr == off_hour) begin
                        alarm_hours[g] <= reg_wdata & `RTCAM_HOUR_MASK;
                    end else if (reg_addr == off_date) begin
                        alarm_date[g] <= reg_wdata & `RTCAM_DATE_MASK;
                    end else if (reg_addr == off_month) begin
                        alarm_month[g] <= reg_wdata & `RTCAM_MONTH_MASK;
                    end else if (weekday_write[g]) begin
                        alarm_match_select[g] <= reg_wdata[6:4];
                        weekday_value[g]      <= reg_wdata[2:0];
                    end
                end
            end

            // 12-hour codes carry AM/PM in bit 5, so bits 5-0 compare
            // in both formats; the format bit is the timekeeping one
            assign sec_eq   = (time_seconds & `RTCAM_SEC_MASK)
                              == alarm_seconds[g];
            assign min_eq   = (time_minutes & `RTCAM_SEC_MASK)
                              == alarm_minutes[g];
            assign hour_eq  = (time_hours & `RTCAM_HOUR_MASK)
                              == alarm_hours[g];
            assign wk_eq    = time_weekday[2:0] == weekday_value[g];
            assign date_eq  = (time_date & `RTCAM_DATE_MASK) == alarm_date[g];
            assign month_eq = (time_month & `RTCAM_MONTH_MASK)
                              == alarm_month[g];

            // reserved codes never match; host must avoid them
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    match_now[g] <= 1'b0;
                end else if (!enabled) begin
                    match_now[g] <= 1'b0;
                end else if (time_update) begin
                    case (alarm_match_select[g])
                        `RTCAM_SEL_SEC:   match_now[g] <= sec_eq;
                        `RTCAM_SEL_MIN:   match_now[g] <= min_eq;
                        `RTCAM_SEL_HOUR:  match_now[g] <= hour_eq;
                        `RTCAM_SEL_WEEKDAY: match_now[g] <= wk_eq;
                        `RTCAM_SEL_DATE:  match_now[g] <= date_eq;
                        `RTCAM_SEL_ALL:   match_now[g] <= sec_eq && min_eq
                            && hour_eq && wk_eq && date_eq && month_eq;
                        default:          match_now[g] <= 1'b0;
                    endcase
                end
            end

            // set wins over the clearing write, so a lasting match
            // re-raises the flag at once
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    alarm_match_flag[g] <= 1'b0;
                end else if (match_now[g]) begin
                    alarm_match_flag[g] <= 1'b1;
                end else if (weekday_write[g]) begin
                    alarm_match_flag[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // read mux, answered one cycle after the strobe
    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == `RTCAM_OFF_CONTROL) begin
            next_rdata = rtc_control;
        end else if (reg_addr == `RTCAM_OFF_A0_SEC) begin
            next_rdata = alarm_seconds[0];
        end else if (reg_addr == `RTCAM_OFF_A0_MIN) begin
            next_rdata = alarm_minutes[0];
        end else if (reg_addr == `RTCAM_OFF_A0_HOUR) begin
            next_rdata = alarm_hours[0];
            next_rdata[`RTCAM_HOUR_FMT] = hour_format;
        end else if (reg_addr == `RTCAM_OFF_A0_WEEKDAY) begin
            next_rdata = {alarm_output_polarity, alarm_match_select[0],
                          alarm_match_flag[0], weekday_value[0]};
        end else if (reg_addr == `RTCAM_OFF_A0_DATE) begin
            next_rdata = alarm_date[0];
        end else if (reg_addr == `RTCAM_OFF_A0_MONTH) begin
            next_rdata = alarm_month[0];
        end else if (reg_addr == `RTCAM_OFF_A1_SEC) begin
            next_rdata = alarm_seconds[1];
        end else if (reg_addr == `RTCAM_OFF_A1_MIN) begin
            next_rdata = alarm_minutes[1];
        end else if (reg_addr == `RTCAM_OFF_A1_HOUR) begin
            next_rdata = alarm_hours[1];
            next_rdata[`RTCAM_HOUR_FMT] = hour_format;
        end else if (reg_addr == `RTCAM_OFF_A1_WEEKDAY) begin
            next_rdata = {alarm_output_polarity, alarm_match_select[1],
                          alarm_match_flag[1], weekday_value[1]};
        end else if (reg_addr == `RTCAM_OFF_A1_DATE) begin
            next_rdata = alarm_date[1];
        end else if (reg_addr == `RTCAM_OFF_A1_MONTH) begin
            next_rdata = alarm_month[1];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end
    end

    // postscaler counts oscillator rising edges; trim_add adds one count and
    // trim_drop swallows one only in a rising-edge cycle, so only the divided taps see trimming
    assign osc_rise = osc_level && !osc_prev;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev  <= 1'b0;
            div_count <= '0;
        end else begin
            osc_prev <= osc_level;
            if (trim_add && !trim_drop) begin
                div_count <= div_count + (osc_rise ? DIV_WIDTH'(2)
                                                   : DIV_WIDTH'(1));
            end else if (trim_drop && !trim_add) begin
                div_count <= div_count;
            end else if (osc_rise) begin
                div_count <= div_count + DIV_WIDTH'(1);
            end
        end
    end

    always_comb begin
        if (rtc_control[`RTCAM_CTL_TRIM]) begin
            sqw_level = div_count[`RTCAM_TAP_64HZ];
        end else begin
            case (rtc_control[1:0])
                `RTCAM_RATE_1HZ:  sqw_level = div_count[`RTCAM_TAP_1HZ];
                `RTCAM_RATE_4K:   sqw_level = div_count[`RTCAM_TAP_DIV8];
                `RTCAM_RATE_8K:   sqw_level = div_count[`RTCAM_TAP_DIV4];
                default:          sqw_level = osc_level;
            endcase
        end
    end

    always_comb begin
        if (rtc_control[`RTCAM_CTL_SQW_EN]) begin
            mode = RTCAM_MODE_SQW;
        end else if (rtc_control[`RTCAM_CTL_A0_EN]
                     || rtc_control[`RTCAM_CTL_A1_EN]) begin
            mode = RTCAM_MODE_ALARM;
        end else begin
            mode = RTCAM_MODE_GPIO;
        end
    end

    always_comb begin
        case (rtc_control[`RTCAM_CTL_A1_EN:`RTCAM_CTL_A0_EN])
            2'b01:   alarm_level = alarm_match_flag[0];
            2'b10:   alarm_level = alarm_match_flag[1];
            default: alarm_level = alarm_output_polarity
                         ? |alarm_match_flag : &alarm_match_flag;
        endcase
    end

    always_comb begin
        case (mode)
            RTCAM_MODE_SQW:   next_pin_level = sqw_level;
            RTCAM_MODE_ALARM: next_pin_level =
                alarm_output_polarity ? alarm_level : !alarm_level;
            default: next_pin_level = rtc_control[`RTCAM_CTL_LEVEL];
        endcase
    end

    // a high level only releases the line; the pull-up makes it high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            multifunction_output_pin_out <= 1'b0;
            multifunction_output_pin_oe  <= 1'b0;
        end else begin
            multifunction_output_pin_out <= 1'b0;
            multifunction_output_pin_oe  <= !next_pin_level;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            external_clock_input_select <= 1'b0;
            first_alarm_flag            <= 1'b0;
            second_alarm_flag           <= 1'b0;
        end else begin
            external_clock_input_select <= rtc_control[`RTCAM_CTL_EXT_CLK];
            first_alarm_flag            <= alarm_match_flag[0];
            second_alarm_flag           <= alarm_match_flag[1];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_clear_write(int i);
        weekday_write[i] && !match_now[i];
    endsequence
    a_flag_on_match: assert property (
        match_now[0] |=> alarm_match_flag[0] ##1 first_alarm_flag)
        else $error("alarm 0 flag missed a match");
    a_flag_stays_set: assert property (
        alarm_match_flag[1] && !weekday_write[1] |=> alarm_match_flag[1])
        else $error("alarm 1 flag dropped without a write");
    a_write_clears: assert property (
        s_clear_write(0) |=> !alarm_match_flag[0])
        else $error("weekday write did not clear alarm 0 flag");
    a_flag_resets: assert property (
        weekday_write[0] && match_now[0] |=> alarm_match_flag[0])
        else $error("flag lost while match persists");
    a_write_no_set: assert property (
        !match_now[1] && !alarm_match_flag[1] |=> !alarm_match_flag[1])
        else $error("alarm 1 flag set without match");
    a_gpio_level: assert property (
        mode == RTCAM_MODE_GPIO |=> multifunction_output_pin_oe
            == !$past(rtc_control[`RTCAM_CTL_LEVEL]))
        else $error("general output level wrong");
    a_single_alarm: assert property (
        mode == RTCAM_MODE_ALARM && rtc_control[5:4] == 2'b01
        |=> multifunction_output_pin_oe == ($past(alarm_output_polarity)
            != $past(alarm_match_flag[0])))
        else $error("single alarm pin level wrong");
    a_dual_alarm: assert property (
        mode == RTCAM_MODE_ALARM && rtc_control[5:4] == 2'b11
        && !alarm_output_polarity
        |=> multifunction_output_pin_oe == $past(&alarm_match_flag))
        else $error("dual alarm low polarity wrong");
    a_open_drain: assert property (
        !multifunction_output_pin_out)
        else $error("pin driven high");
    a_date_reserved: assert property (
        reg_read && reg_addr == `RTCAM_OFF_A0_DATE
        |=> reg_rdata[7:6] == 2'b00)
        else $error("reserved alarm date bits set");
    a_month_reserved: assert property (
        reg_read && reg_addr == `RTCAM_OFF_A0_MONTH
        |=> reg_rdata[7:5] == 3'b000)
        else $error("reserved alarm month bits set");
    a_ext_clock: assert property (
        ##1 external_clock_input_select
            == $past(rtc_control[`RTCAM_CTL_EXT_CLK]))
        else $error("external clock select lags");

endmodule : rtcam_alarm_output

// ---- test/rtcam_host.sv ----
/* host model on the register strobe port, clocked with the block. */
module rtcam_host
    import rtcam_pkg::*;
(
    input  wire logic       clock,
    output logic            reg_write = 1'b0,
    output logic            reg_read  = 1'b0,
    output logic      [7:0] reg_addr  = 8'h00,
    output logic      [7:0] reg_wdata = 8'h00,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic io(input logic w, input logic [7:0] ad,
                      input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        #1;
        reg_addr  = ad;
        reg_wdata = d; // no reserved select weekday 1-7
        {reg_write, reg_read} = {w, !w};
        @(posedge clock);
        #1;
        {reg_write, reg_read} = 2'b00;
        reg_wdata = ~d; // released bus must not keep the last byte
        q = reg_rdata;
    endtask : io
endmodule : rtcam_host

// ---- test/rtcam_alarm_output_test.sv ----
/* bench of alarm compare and pin; assumes rtcam_host, pin pull-up. */
module rtcam_alarm_output_test
    import rtcam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock = 1'b0, reset_n = 1'b0, time_update = 1'b0;
    logic       osc_level = 1'b0, reg_write, reg_read;
    logic       pin_out, pin_oe, ext_sel, f0, f1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [7:0] tv [6] = '{default: 8'h00};
    logic [7:0] a [6] = '{8'h25, 8'h41, 8'h13, 8'h03, 8'h17, 8'h09};
    logic [7:0] b [6] = '{8'h26, 8'h42, 8'h14, 8'h04, 8'h18, 8'h10};
    int         err_total = 0, n_compared = 0;
    wire logic  pin = pin_oe ? pin_out : 1'b1; // pull-up
    rtcam_host u_host (.clock, .reg_write, .reg_read, .reg_addr,
                       .reg_wdata, .reg_rdata);
    rtcam_alarm_output #(.DIV_WIDTH(15)) u_rtcam_alarm_output (
        .clock, .reset_n, .reg_write, .reg_read, .reg_addr, .reg_wdata,
        .reg_rdata, .time_update, .time_seconds(tv[0]), .osc_level,
        .time_minutes(tv[1]), .time_hours(tv[2]), .time_weekday(tv[3]),
        .time_date(tv[4]), .time_month(tv[5]), .trim_add(1'b0),
        .trim_drop(1'b0), .multifunction_output_pin_out(pin_out),
        .multifunction_output_pin_oe(pin_oe), .first_alarm_flag(f0),
        .external_clock_input_select(ext_sel), .second_alarm_flag(f1));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic nap();
        repeat (3) @(posedge clock);
        #1;
    endtask : nap
    task automatic upd(input logic [5:0] use_a);
        foreach (tv[j]) tv[j] = use_a[j] ? a[j] : b[j];
        @(posedge clock);
        #1;
        time_update = 1'b1;
        @(posedge clock);
        #1;
        time_update = 1'b0;
        nap();
    endtask : upd
    task automatic t_regs();
        logic [7:0] ad [9] = '{8'h07, 8'h0D, 8'h0E, 8'h0F, 8'h0A, 8'h08,
                               8'h0E, 8'h0F, 8'h0D};
        logic [7:0] ex [9] = '{8'h80, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00,
                               8'h3F, 8'h1F, 8'h07};
        logic [7:0] wd [3] = '{8'hFF, 8'hFF, 8'h0F};
        for (int i = 0; i < 9; i++) begin
            if (i > 5) begin
                u_host.io(1'b1, ad[i], wd[i-6], rv);
            end
            u_host.io(1'b0, ad[i], 8'h00, rv);
            chk(rv, ex[i]);
        end
        u_host.io(1'b1, 8'h07, 8'h08, rv);
        nap();
        chk({6'h0, pin, ext_sel}, 8'h01);
    endtask : t_regs
    task automatic t_select();
        logic [2:0] cs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
        int         f;
        foreach (a[j]) u_host.io(1'b1, 8'h0A + 8'(j), a[j], rv);
        u_host.io(1'b1, 8'h07, 8'h10, rv);
        for (int i = 0; i < 6; i++) begin
            f = (cs[i] == 3'h7) ? 5 : int'(cs[i]);
            u_host.io(1'b1, 8'h0D, {cs[i][0], cs[i], 4'h3}, rv);
            nap();
            chk({7'h0, f0}, {7'h0, i > 0});
            upd(~(6'h01 << f));
            chk({7'h0, f0}, {7'h0, i > 0});
            u_host.io(1'b1, 8'h0D, {cs[i][0], cs[i], 4'h3}, rv);
            nap();
            chk({6'h0, f0, pin}, {7'h0, ~cs[i][0]});
            upd((cs[i] == 3'h7) ? 6'h3F : 6'h01 << f);
            chk({6'h0, f0, pin}, {6'h1, cs[i][0]});
        end
    endtask : t_select
    task automatic t_dual();
        u_host.io(1'b1, 8'h11, b[0], rv);
        u_host.io(1'b1, 8'h07, 8'h30, rv);
        u_host.io(1'b1, 8'h14, 8'h01, rv);
        u_host.io(1'b0, 8'h0D, 8'h00, rv);
        chk(rv, 8'h7B);
        chk({6'h0, f1, pin}, 8'h01);
        upd(6'h00);
        chk({6'h0, f1, pin}, 8'h02);
        u_host.io(1'b1, 8'h0D, 8'h83, rv);
        nap();
        chk({6'h0, f0, pin}, 8'h01);
    endtask : t_dual
    task automatic t_square();
        logic [7:0] ctl [4] = '{8'h73, 8'h71, 8'h72, 8'h74};
        int         win [4] = '{64, 64, 64, 8192};
        logic [7:0] want [4] = '{8'h08, 8'h01, 8'h02, 8'h02};
        logic [7:0] n;
        logic       last;
        for (int i = 0; i < 4; i++) begin
            u_host.io(1'b1, 8'h07, ctl[i], rv);
            repeat (130) @(posedge clock);
            #1;
            last = pin;
            n = 8'h00;
            repeat (win[i]) begin
                @(posedge clock);
                #1;
                n = n + {7'h0, pin ^ last};
                last = pin;
            end
            chk(n, want[i]);
        end
    endtask : t_square
    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    initial forever #5 clock = ~clock;
    initial forever begin
        repeat (8) @(posedge clock);
        #1;
        osc_level = ~osc_level; // 16 clocks a period, well below clock/2
    end
    initial begin
        repeat (16) @(posedge clock);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge clock);
        t_regs();
        t_select();
        t_dual();
        t_square();
        end_of_test();
    end
    initial begin
        #300us; // about three times the expected run
        err_total++;
        end_of_test();
    end
endmodule : rtcam_alarm_output_test
